// ===== logic/csm_monitor.sv
// Change detect and event sequence log monitor for 32 inputs
//
// Chosen here: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`include "csm_map.svh"
module csm_monitor
    import csm_pkg::*;
#(
    parameter int EVT_DEPTH = `CSM_EVENT_DEPTH,
    parameter int TICK_CYCLES = `CSM_TICK_CYCLES
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic RST,
    // Register port
    input wire logic [7:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic [3:0] BE,
    input wire logic WR,
    input wire logic RD,
    output logic [31:0] RDATA,
    // Input pins and counter value
    input wire logic [31:0] DIN,
    input wire logic [31:0] QCOUNT,
    // Interrupt request and acknowledge
    output logic IRQ_REQ,
    input wire logic IACK,
    output logic [7:0] VECTOR,
    output logic VEC_VALID
);
    localparam int TW = $clog2(TICK_CYCLES + 1);
    localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);

    csm_fifo_if #(.WIDTH(32), .DEPTH(EVT_DEPTH)) evt_bus ();
    csm_fifo_if #(.WIDTH(32), .DEPTH(EVT_DEPTH)) stamp_bus ();

    logic [31:0] sync1;
    logic [31:0] sync2;
    logic [31:0] sync3;
    logic [31:0] live;
    logic [31:0] test_pat;
    logic [31:0] eff_data;
    logic [31:0] prev;
    logic [31:0] after_word;
    logic [63:0] trig_sel;
    logic [31:0] hits;
    logic [TW-1:0] tick_cnt;
    logic tick;
    logic detect_en;
    logic seq_mode;
    logic stamp_en;
    logic rel_ack;
    logic irq_en;
    logic test_mode;
    logic overflow;
    logic irq_pend;
    logic [7:0] vector;
    csm_ev_state_type ev_state;
    logic log_event;
    logic log_set;
    logic wr_ctrl;
    logic wr_data;
    logic [31:0] next_rdata;
    logic [31:0] rd_reg;
    logic [3:0] rd_mask;
    logic rd_evt;
    logic rd_stamp;

    function automatic logic edge_hit(input logic old_v, input logic new_v,
            input logic [1:0] sel);
        case (csm_trig_type'(sel))
            TRIG_RISE: edge_hit = !old_v && new_v;
            TRIG_FALL: edge_hit = old_v && !new_v;
            TRIG_ANY: edge_hit = old_v != new_v;
            default: edge_hit = 1'b0;
        endcase
    endfunction

    function automatic logic [31:0] lane_merge(input logic [31:0] old_w,
            input logic [31:0] new_w, input logic [3:0] be);
        for (int i = 0; i < 4; i++) begin
            old_w[i*8 +: 8] = be[i] ? new_w[i*8 +: 8] : old_w[i*8 +: 8];
        end
        lane_merge = old_w;
    endfunction

    // Pin inputs: three stages, a bit moves only when stages two and three agree
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            sync1 <= '0;
            sync2 <= '0;
            sync3 <= '0;
            live <= '0;
        end else begin
            sync1 <= DIN;
            sync2 <= sync1;
            sync3 <= sync2;
            live <= (sync2 & sync3) | (live & (sync2 ^ sync3));
        end
    end

    // Test patterns never reach the pins, only the internal path
    assign eff_data = test_mode ? test_pat : live; // [R12] [R13]

    assign wr_ctrl = WR && ADDR == `CSM_ADDR_CTRL;
    assign wr_data = WR && ADDR == `CSM_ADDR_DATA;

    // Control bits; test mode may be set at any moment
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            {test_mode, irq_en, rel_ack, stamp_en, seq_mode, detect_en} <= `CSM_CTRL_RESET;
        end else if (wr_ctrl) begin
            detect_en <= WDATA[`CSM_BIT_DETECT];
            seq_mode <= WDATA[`CSM_BIT_SEQ];
            stamp_en <= WDATA[`CSM_BIT_STAMP];
            rel_ack <= WDATA[`CSM_BIT_REL_ACK];
            irq_en <= WDATA[`CSM_BIT_IRQ_EN];
            test_mode <= WDATA[`CSM_BIT_TEST]; // [R14]
        end
    end

    // Patterns land only while test mode is on, at the data port address
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            test_pat <= '0;
        end else if (wr_data && test_mode) begin
            test_pat <= lane_merge(test_pat, WDATA, BE); // [R11]
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            trig_sel <= '0;
        end else if (WR && ADDR == `CSM_ADDR_TRIG_LO) begin
            trig_sel[31:0] <= lane_merge(trig_sel[31:0], WDATA, BE); // [R2]
        end else if (WR && ADDR == `CSM_ADDR_TRIG_HI) begin
            trig_sel[63:32] <= lane_merge(trig_sel[63:32], WDATA, BE); // [R2]
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            vector <= `CSM_VECTOR_RESET;
        end else if (WR && ADDR == `CSM_ADDR_VECTOR && BE[0]) begin
            vector <= WDATA[7:0];
        end
    end

    // Sample tick
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            tick_cnt <= '0;
        end else if (tick) begin
            tick_cnt <= '0;
        end else begin
            tick_cnt <= tick_cnt + 1'b1;
        end
    end
    assign tick = tick_cnt == TICK_LAST;

    always_comb begin
        for (int c = 0; c < 32; c++) begin
            hits[c] = edge_hit(prev[c], eff_data[c], trig_sel[c*2 +: 2]); // [R18] [R2]
        end
    end

    // A change seen while the second word is pending waits for the next tick
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            prev <= '0;
        end else if (tick && ev_state == EV_IDLE) begin
            prev <= eff_data; // [R18]
        end
    end

    assign log_event = tick && ev_state == EV_IDLE && detect_en && |hits; // [R5]
    assign log_set = log_event && evt_bus.in_ready;

    // First word is the prior state in sequence mode, else the new state
    assign evt_bus.in_valid = log_event || ev_state == EV_SECOND;
    assign evt_bus.in_data = ev_state == EV_SECOND ? after_word :
        (seq_mode ? prev : eff_data); // [R8]
    assign stamp_bus.in_valid = log_set && stamp_en; // [R9] [R10]
    assign stamp_bus.in_data = QCOUNT;

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            ev_state <= EV_IDLE;
            after_word <= '0;
        end else begin
            case (ev_state)
                EV_IDLE: begin
                    if (log_set && seq_mode) begin
                        ev_state <= EV_SECOND; // [R8]
                        after_word <= eff_data;
                    end
                end
                EV_SECOND: begin
                    if (evt_bus.in_ready) begin
                        ev_state <= EV_IDLE;
                    end
                end
                default: ev_state <= EV_IDLE;
            endcase
        end
    end

    // Sticky overflow; a new loss beats a clear in the same cycle
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            overflow <= 1'b0;
        end else if ((log_event && !evt_bus.in_ready) ||
                (stamp_bus.in_valid && !stamp_bus.in_ready)) begin
            overflow <= 1'b1; // [R19]
        end else if (wr_ctrl && WDATA[`CSM_BIT_OVERFLOW]) begin
            overflow <= 1'b0;
        end
    end

    // Pending survives while interrupts are off; new event beats release
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            irq_pend <= 1'b0;
        end else if (log_set) begin
            irq_pend <= 1'b1; // [R5] [R7]
        end else if (rel_ack && IACK && IRQ_REQ) begin
            irq_pend <= 1'b0; // [R6]
        end else if (!rel_ack && !evt_bus.out_valid && ev_state == EV_IDLE) begin
            irq_pend <= 1'b0; // [R6] [R17]
        end
    end
    assign IRQ_REQ = irq_pend && irq_en; // [R7]

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            VECTOR <= '0;
            VEC_VALID <= 1'b0;
        end else begin
            VEC_VALID <= IACK && IRQ_REQ;
            VECTOR <= (IACK && IRQ_REQ) ? vector : 8'h00; // [R16]
        end
    end

    // Only reads of the store addresses pop; data port reads are side-effect free
    assign evt_bus.out_ready = RD && ADDR == `CSM_ADDR_EVENT; // [R17] [R15]
    assign stamp_bus.out_ready = RD && ADDR == `CSM_ADDR_STAMP; // [R15]

    always_comb begin
        next_rdata = '0;
        case (ADDR)
            `CSM_ADDR_CTRL: begin
                next_rdata[5:0] = {test_mode, irq_en, rel_ack, stamp_en, seq_mode, detect_en};
                next_rdata[`CSM_BIT_OVERFLOW] = overflow;
                next_rdata[`CSM_BIT_PENDING] = irq_pend;
                next_rdata[`CSM_BIT_EMPTY] = !evt_bus.out_valid;
            end
            `CSM_ADDR_DATA: next_rdata = eff_data; // [R4] [R3]
            `CSM_ADDR_TRIG_LO: next_rdata = trig_sel[31:0];
            `CSM_ADDR_TRIG_HI: next_rdata = trig_sel[63:32];
            `CSM_ADDR_LEVEL: next_rdata = {16'(stamp_bus.level), 16'(evt_bus.level)};
            `CSM_ADDR_VECTOR: next_rdata = {24'h000000, vector};
            default: next_rdata = '0;
        endcase
    end

    // Store words come straight from the store's registered output
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            rd_reg <= '0;
            rd_mask <= 4'h0;
            rd_evt <= 1'b0;
            rd_stamp <= 1'b0;
        end else begin
            rd_reg <= RD ? next_rdata : 32'h00000000;
            rd_mask <= RD ? BE : 4'h0; // [R4]
            rd_evt <= evt_bus.out_ready && evt_bus.out_valid;
            rd_stamp <= stamp_bus.out_ready && stamp_bus.out_valid;
        end
    end

    always_comb begin
        RDATA = rd_evt ? evt_bus.out_data : (rd_stamp ? stamp_bus.out_data : rd_reg);
        for (int i = 0; i < 4; i++) begin
            RDATA[i*8 +: 8] = rd_mask[i] ? RDATA[i*8 +: 8] : 8'h00; // [R4]
        end
    end

    csm_fifo #(.WIDTH(32), .DEPTH(EVT_DEPTH)) u_evt_fifo (
        .clk(CLK),
        .rst(RST),
        .port(evt_bus)
    ); // [R1]

    csm_fifo #(.WIDTH(32), .DEPTH(EVT_DEPTH)) u_stamp_fifo (
        .clk(CLK),
        .rst(RST),
        .port(stamp_bus)
    ); // [R9]

    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    sequence s_seq_first;
        log_set && seq_mode;
    endsequence
    sequence s_seq_second;
        ev_state == EV_SECOND && evt_bus.in_valid && evt_bus.in_data == after_word;
    endsequence

    AST_SEQ_PAIR: assert property (s_seq_first |=> s_seq_second) // [R8]
        else $error("sequence mode did not follow with after word");
    AST_PEND_SET: assert property (log_set |=> irq_pend) // [R5]
        else $error("logged event left request clear");
    AST_OVERFLOW: assert property (log_event && !evt_bus.in_ready |=> overflow) // [R19]
        else $error("discarded event did not set overflow");
    AST_POP_SOURCE: assert property (evt_bus.out_ready |-> RD && ADDR == `CSM_ADDR_EVENT) // [R15]
        else $error("store popped without store read");
    AST_TEST_WRITE: assert property (wr_data && test_mode && BE == 4'hF && !wr_ctrl ##1
        test_mode |-> eff_data == $past(WDATA)) // [R11]
        else $error("test pattern not seen on data path");
    AST_LIVE_BACK: assert property (!test_mode |-> eff_data == live) // [R13]
        else $error("live inputs not used outside test mode");
    AST_ACK_RELEASE: assert property (rel_ack && IACK && IRQ_REQ && !log_set |=> !irq_pend) // [R6]
        else $error("acknowledge did not release request");
    AST_EMPTY_RELEASE: assert property (!rel_ack && !log_set && !evt_bus.out_valid &&
        ev_state == EV_IDLE |=> !irq_pend) // [R17]
        else $error("empty store did not release request");
    AST_VECTOR: assert property (IACK && IRQ_REQ |=> VEC_VALID && VECTOR == $past(vector)) // [R16]
        else $error("acknowledge answer lacks vector");
    AST_REENABLE: assert property (irq_pend && !irq_en ##1 irq_en && irq_pend |-> IRQ_REQ) // [R7]
        else $error("held change not raised on enable");
    AST_STAMP: assert property (log_set && stamp_en |-> stamp_bus.in_valid) // [R9] [R10]
        else $error("counter value not offered for event");
    // A lost time stamp is flagged too, though its event word is kept
    AST_STAMP_LOSS: assert property (stamp_bus.in_valid && !stamp_bus.in_ready |=> overflow) // [R19]
        else $error("discarded counter value did not set overflow");
    AST_VEC_QUIET: assert property (!(IACK && IRQ_REQ) |=> !VEC_VALID && VECTOR == 8'h00) // [R16]
        else $error("vector shown without acknowledge");
    AST_MASKED: assert property (!irq_en |-> !IRQ_REQ) // [R7]
        else $error("request raised while interrupts are off");
    AST_DATA_QUIET: assert property (RD && ADDR == `CSM_ADDR_DATA |-> !evt_bus.out_ready && !stamp_bus.out_ready) // [R15]
        else $error("data port read popped a store");
endmodule

// ===== logic/csm_map.svh
// Offsets, field positions, reset values and timing counts of the input monitor
// What this block does
// [R1] Event store holds 512 entries while detecting
// [R2] Per-channel trigger: none, rise, fall, any
// [R3] Inputs grouped as four eight-bit ports
// [R4] Data reads live, 8/16/32-bit wide
// [R5] Selected change raises interrupt request
// [R6] Request released on empty or acknowledge
// [R7] Pending change kept until interrupts enabled
// [R8] Sequence mode logs before then after state
// [R9] Counter value optionally logged per event
// [R10] Counter logging works in both modes
// [R11] Test patterns share data port address
// [R12] Test patterns replace internal input data only
// [R13] Test mode off restores live inputs
// [R14] Test mode settable anytime by control bit
// [R15] Data reads never touch detection or stores
// [R16] Acknowledge answer carries programmed vector
// [R17] Store reads empty it, dropping request
// [R18] Edge found comparing new and previous sample
// [R19] Full store discards event, sets overflow
`ifndef CSM_MAP_SVH
`define CSM_MAP_SVH

`define CSM_ADDR_CTRL 8'h00
`define CSM_ADDR_DATA 8'h04
`define CSM_ADDR_TRIG_LO 8'h08
`define CSM_ADDR_TRIG_HI 8'h0C
`define CSM_ADDR_EVENT 8'h10
`define CSM_ADDR_STAMP 8'h14
`define CSM_ADDR_LEVEL 8'h18
`define CSM_ADDR_VECTOR 8'h1C

`define CSM_BIT_DETECT 0
`define CSM_BIT_SEQ 1
`define CSM_BIT_STAMP 2
`define CSM_BIT_REL_ACK 3
`define CSM_BIT_IRQ_EN 4
`define CSM_BIT_TEST 5
`define CSM_BIT_OVERFLOW 8
`define CSM_BIT_PENDING 9
`define CSM_BIT_EMPTY 10

`define CSM_CTRL_RESET 6'h00
`define CSM_VECTOR_RESET 8'h00
`define CSM_EVENT_DEPTH 512
`define CSM_TICK_CYCLES 16

`endif

// ===== logic/csm_pkg.sv
// Types shared by the input monitor modules
package csm_pkg;
    typedef enum logic [1:0] {
        TRIG_NONE,
        TRIG_RISE,
        TRIG_FALL,
        TRIG_ANY
    } csm_trig_type;
    typedef enum logic {
        EV_IDLE,
        EV_SECOND
    } csm_ev_state_type;
endpackage

// ===== logic/csm_fifo_if.sv
// Push and pop signals between the monitor and one store
`timescale 1ns/1ps
interface csm_fifo_if #(parameter int WIDTH = 32, parameter int DEPTH = 512);
    logic in_valid;
    logic in_ready;
    logic [WIDTH-1:0] in_data;
    logic out_valid;
    logic out_ready;
    logic [WIDTH-1:0] out_data;
    logic [$clog2(DEPTH):0] level;
    modport fifo (input in_valid, in_data, out_ready,
        output in_ready, out_valid, out_data, level);
    modport user (output in_valid, in_data, out_ready,
        input in_ready, out_valid, out_data, level);
endinterface

// ===== logic/csm_fifo.sv
// Store with registered pop data; DEPTH must be a power of two
`timescale 1ns/1ps
module csm_fifo #(parameter int WIDTH = 32, parameter int DEPTH = 512) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Push and pop side
    csm_fifo_if.fifo port
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_LEVEL = (AW+1)'(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr;
    logic [AW:0] rd_ptr;
    logic [WIDTH-1:0] rd_data;
    logic push;
    logic pop;

    assign port.level = wr_ptr - rd_ptr;
    assign port.in_ready = port.level != FULL_LEVEL;
    assign port.out_valid = port.level != '0;
    assign port.out_data = rd_data;
    assign push = port.in_valid & port.in_ready;
    assign pop = port.out_ready & port.out_valid;

    // Memory has no reset so it maps onto block RAM
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr[AW-1:0]] <= port.in_data;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_ptr <= '0;
        end else if (push) begin
            wr_ptr <= wr_ptr + 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rd_ptr <= '0;
            rd_data <= '0;
        end else if (pop) begin
            rd_ptr <= rd_ptr + 1'b1;
            rd_data <= mem[rd_ptr[AW-1:0]];
        end
    end

    AST_FIFO_BOUND: assert property (@(posedge clk) disable iff (rst) // [R1]
        port.level <= FULL_LEVEL)
        else $error("store level above depth");
endmodule

// ===== testbench/csm_host_model.sv
// Host side of the interrupt lines: slow acknowledge and vector capture
`timescale 1ns/1ps
module csm_host_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Bench control
    input wire logic ack_enable,
    input wire logic [3:0] ack_delay,
    // Interrupt lines
    input wire logic irq_req,
    output logic iack,
    input wire logic [7:0] vector,
    input wire logic vec_valid,
    // Results seen
    output logic [7:0] last_vector,
    output logic [7:0] ack_count
);
    logic [3:0] wait_count;

    // Request must stand ack_delay cycles; one-cycle acknowledge only
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            iack <= 1'b0;
            wait_count <= 4'h0;
        end else if (iack) begin
            iack <= 1'b0;
            wait_count <= 4'h0;
        end else if (ack_enable && irq_req && wait_count >= ack_delay) begin
            iack <= 1'b1;
        end else if (irq_req) begin
            wait_count <= wait_count + 4'h1;
        end
    end

    // Vector taken only in the cycle it is flagged
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            last_vector <= 8'h00;
            ack_count <= 8'h00;
        end else if (vec_valid) begin
            last_vector <= vector;
            ack_count <= ack_count + 8'h01;
        end
    end
endmodule

// ===== testbench/csm_monitor_test.sv
// Self-checking bench for the input monitor
`timescale 1ns/1ps
`include "csm_map.svh"
module csm_monitor_test;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0] be = 4'hF;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [31:0] din = 32'h0;
    logic [31:0] qcount = 32'h0;
    logic ack_en = 1'b0;
    logic [31:0] rdata;
    logic irq_req;
    logic iack;
    logic vec_valid;
    logic [7:0] vector;
    logic [7:0] last_vector;
    logic [7:0] ack_count;
    int errors = 0;
    int check_count = 0;
    int cycles = 0;
    int n;

    always #50 clk = ~clk;

    // Short store and tick keep the run brief
    csm_monitor #(.EVT_DEPTH(8), .TICK_CYCLES(2)) DUT (.CLK(clk), .RST(rst), .ADDR(addr),
        .WDATA(wdata), .BE(be), .WR(wr), .RD(rd), .RDATA(rdata), .DIN(din), .QCOUNT(qcount),
        .IRQ_REQ(irq_req), .IACK(iack), .VECTOR(vector), .VEC_VALID(vec_valid));
    csm_host_model host (.clk(clk), .rst(rst), .ack_enable(ack_en), .ack_delay(4'h3),
        .irq_req(irq_req), .iack(iack), .vector(vector), .vec_valid(vec_valid),
        .last_vector(last_vector), .ack_count(ack_count));

    task automatic tally_and_finish();
        if (errors == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic cmp(input string name, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic idle(input int c);
        repeat (c) @(posedge clk);
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d, input logic [3:0] b = 4'hF);
        addr <= a;
        wdata <= d;
        be <= b;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        // One quiet edge so back-to-back writes never set the strobe twice at once
        @(posedge clk);
    endtask

    // Read data stand one cycle only, so they are taken mid-cycle
    task automatic rd_cmp(input string name, input logic [7:0] a, input logic [31:0] exp,
        input logic [3:0] b = 4'hF);
        addr <= a;
        be <= b;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        cmp(name, exp, rdata);
        @(posedge clk);
    endtask

    task automatic chk_irq(input logic exp);
        @(negedge clk);
        cmp("request", {31'h0, exp}, {31'h0, irq_req});
        @(posedge clk);
    endtask

    // Hang guard, well above the expected run
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            errors++;
            tally_and_finish();
        end
    end

    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd_cmp("control", `CSM_ADDR_CTRL, 32'h400);
        rd_cmp("vector", `CSM_ADDR_VECTOR, 32'h0);
        rd_cmp("unmapped", 8'h20, 32'h0);
        // Live port reads at three widths
        din <= 32'hA5C3_0F81;
        idle(6);
        rd_cmp("data word", `CSM_ADDR_DATA, 32'hA5C3_0F81);
        rd_cmp("data port 2", `CSM_ADDR_DATA, 32'h00C3_0000, 4'h4);
        rd_cmp("data half", `CSM_ADDR_DATA, 32'hA5C3_0000, 4'hC);
        rd_cmp("level after reads", `CSM_ADDR_LEVEL, 32'h0);
        // Each trigger setting on channel 0, rise then fall
        din <= 32'h0;
        qcount <= 32'h5EED_0001;
        idle(8);
        wr_reg(`CSM_ADDR_CTRL, 32'h15);
        for (int m = 0; m < 4; m++) begin
            wr_reg(`CSM_ADDR_TRIG_LO, 32'(m));
            din[0] <= 1'b1;
            idle(10);
            din[0] <= 1'b0;
            idle(10);
            n = (m == 0) ? 0 : (m == 3) ? 2 : 1;
            rd_cmp("levels", `CSM_ADDR_LEVEL, {16'(n), 16'(n)});
            chk_irq(n != 0);
            for (int k = 0; k < n; k++) begin
                rd_cmp("event word", `CSM_ADDR_EVENT, 32'(m != 2 && k == 0));
                rd_cmp("stamp", `CSM_ADDR_STAMP, 32'h5EED_0001);
            end
            idle(3);
            chk_irq(1'b0);
        end
        // Release on acknowledge; change kept while interrupts are off
        wr_reg(`CSM_ADDR_CTRL, 32'h09);
        wr_reg(`CSM_ADDR_VECTOR, 32'h5A);
        din[0] <= 1'b1;
        idle(10);
        chk_irq(1'b0);
        ack_en <= 1'b1;
        wr_reg(`CSM_ADDR_CTRL, 32'h19);
        idle(12);
        chk_irq(1'b0);
        cmp("acks", 32'h1, 32'(ack_count));
        cmp("ack vector", 32'h5A, 32'(last_vector));
        ack_en <= 1'b0;
        rd_cmp("kept event", `CSM_ADDR_EVENT, 32'h1);
        // Sequence log with stamp
        qcount <= 32'h0BAD_F00D;
        wr_reg(`CSM_ADDR_CTRL, 32'h17);
        din <= 32'h0000_0100;
        idle(10);
        rd_cmp("seq levels", `CSM_ADDR_LEVEL, 32'h0001_0002);
        rd_cmp("before", `CSM_ADDR_EVENT, 32'h1);
        rd_cmp("after", `CSM_ADDR_EVENT, 32'h100);
        rd_cmp("seq stamp", `CSM_ADDR_STAMP, 32'h0BAD_F00D);
        // Overflow: ten changes into eight places
        wr_reg(`CSM_ADDR_CTRL, 32'h01);
        for (int k = 0; k < 10; k++) begin
            din[0] <= ~din[0];
            idle(10);
        end
        rd_cmp("full level", `CSM_ADDR_LEVEL, 32'h8);
        rd_cmp("overflow set", `CSM_ADDR_CTRL, 32'h301);
        wr_reg(`CSM_ADDR_CTRL, 32'h101);
        rd_cmp("overflow cleared", `CSM_ADDR_CTRL, 32'h201);
        for (int k = 0; k < 8; k++) begin
            rd_cmp("kept word", `CSM_ADDR_EVENT, 32'h100 | 32'(k % 2 == 0));
        end
        idle(2);
        rd_cmp("drained", `CSM_ADDR_CTRL, 32'h401);
        // Test patterns stand in for the live inputs
        wr_reg(`CSM_ADDR_CTRL, 32'h21);
        wr_reg(`CSM_ADDR_DATA, 32'h0000_0001);
        wr_reg(`CSM_ADDR_DATA, 32'hFFFF_FF00, 4'h2);
        idle(4);
        rd_cmp("pattern", `CSM_ADDR_DATA, 32'h0000_FF01);
        rd_cmp("pattern level", `CSM_ADDR_LEVEL, 32'h1);
        wr_reg(`CSM_ADDR_CTRL, 32'h01);
        idle(4);
        rd_cmp("live again", `CSM_ADDR_DATA, 32'h100);
        rd_cmp("pattern event", `CSM_ADDR_EVENT, 32'h1);
        rd_cmp("live event", `CSM_ADDR_EVENT, 32'h100);
        // Only the low lane of the upper trigger word may change
        wr_reg(`CSM_ADDR_TRIG_HI, 32'hFFFF_FF02, 4'h1);
        rd_cmp("trigger high", `CSM_ADDR_TRIG_HI, 32'h2);
        tally_and_finish();
    end
endmodule
